/* File: self_test_error_handler.sv */
// Self-test error handler: detects, classifies and answers major and minor faults.
// What this block does
// R01 - Diagnose once at start, then continuously.
// R02 - Major fault disables all protection.
// R03 - Major: fault lamp on, in-service off.
// R04 - Major fault drops every relay, watchdog too.
// R05 - Minor: fault lamp, drop watchdog only.
// R06 - Each fault posts a target queue message.
// R07 - Each fault writes an event log entry.
// R08 - Uncorrectable memory corruption is major.
// R09 - Bad logic equation is major, blocks features.
// R10 - Lost signal processor link is major.
// R11 - Unrealistic transformer setup is major.
// R12 - Input contact supply failure is minor.
// R13 - Analog output supply failure is minor.
// R14 - Missing calibration is minor.
// R15 - Stopped clock is minor until rewritten.
// R16 - Lost clock battery is minor.
// R17 - Development firmware loaded is minor.
// R18 - Internal temperature outside limits is minor.
// R19 - Time-code format mismatch is minor.
// R20 - Three wrong passcodes minor; right clears.
// R21 - Ambient temperature outside range is minor.
// R22 - Flash message held programmable seconds, default four.
// R23 - Round setting to step; notice if changed.
// R24 - Major outranks minor; responses withdraw when clear.
//
// Implementation choices: the register addresses and register access over APB.
module self_test_error_handler
  import self_test_pkg::*;
#(
  parameter int NUM_RELAYS = 7,
  parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nvm_uncorrectable,
  input wire logic dsp_link_lost,
  input wire logic logic_supply_ok,
  input wire logic analog_supply_ok,
  input wire logic rtc_osc_ok,
  input wire logic battery_ok,
  input wire logic [1:0] irig_format,
  input wire logic [NUM_RELAYS-1:0] relay_cmd,
  output logic protection_enable,
  output logic eqn_feature_enable,
  output logic fault_led,
  output logic in_service_led,
  output logic [NUM_RELAYS-1:0] relay_drive,
  output logic watchdog_relay,
  output logic rtc_run,
  output logic tq_valid,
  output logic [FW-1:0] tq_code,
  output logic log_valid,
  output logic [FW-1:0] log_code,
  output logic log_major,
  output logic flash_active,
  output logic [7:0] flash_code
);
  localparam int NPIN = 8;

  if (NUM_RELAYS < 1 || NUM_RELAYS > 32) begin : g_bad_relays
    $error("NUM_RELAYS must lie in 1..32");
  end
  if (SEC_CYCLES < 2) begin : g_bad_sec
    $error("SEC_CYCLES must be at least 2");
  end

  // Pin synchronisers: stage one feeds stage two only.
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  assign pin_raw = {irig_format, battery_ok, rtc_osc_ok, analog_supply_ok, logic_supply_ok,
                    dsp_link_lost, nvm_uncorrectable};
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        pin_s1_r[g] <= PIN_SYNC_RST[g];
        pin_s2_r[g] <= PIN_SYNC_RST[g];
      end else if (ce) begin
        pin_s1_r[g] <= pin_raw[g];
        pin_s2_r[g] <= pin_s1_r[g];
      end
    end
  end

  // APB decode.
  logic [31:0] config_r;
  logic [31:0] temps_r;
  logic [31:0] pass_ref_r;
  logic [15:0] step_r;
  logic [15:0] setting_r;
  logic adjusted_r;
  logic [1:0] wrong_cnt_r;
  logic rtc_run_r;
  logic init_done_r;
  logic major_r;
  logic minor_r;
  logic [NUM_FAULTS-1:0] fault_r;
  logic [31:0] rdata_nxt;
  logic [31:0] sec_cnt_r;
  logic [7:0] flash_left_r;

  wire setup = psel & ~penable & ~pready;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire [7:0] addr = paddr[7:0];
  wire addr_hi_ok = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0);
  wire hit_status = addr_hi_ok && addr == OFF_STATUS;
  wire hit_faults = addr_hi_ok && addr == OFF_FAULTS;
  wire hit_config = addr_hi_ok && addr == OFF_CONFIG;
  wire hit_temps = addr_hi_ok && addr == OFF_TEMPS;
  wire hit_pass_ref = addr_hi_ok && addr == OFF_PASS_REF;
  wire hit_pass_try = addr_hi_ok && addr == OFF_PASS_TRY;
  wire hit_rtc_set = addr_hi_ok && addr == OFF_RTC_SET;
  wire hit_step = addr_hi_ok && addr == OFF_STEP;
  wire hit_setting = addr_hi_ok && addr == OFF_SETTING;
  wire hit_flash = addr_hi_ok && addr == OFF_FLASH;
  wire mapped = hit_status | hit_faults | hit_config | hit_temps | hit_pass_ref | hit_pass_try |
                hit_rtc_set | hit_step | hit_setting | hit_flash;

  // Configuration fields.
  wire cfg_calibrated = config_r[0];
  wire cfg_eqn_ok = config_r[1];
  wire cfg_xfmr_ok = config_r[2];
  wire cfg_dev_fw = config_r[3];
  wire [1:0] cfg_irig_type = config_r[5:4];
  wire [7:0] cfg_flash_sec = config_r[15:8];
  wire signed [7:0] int_temp = temps_r[7:0];
  wire signed [9:0] amb_temp = temps_r[25:16];

  // Passcode attempts.
  wire pass_try = wr & hit_pass_try;
  wire pass_good = pwdata == pass_ref_r;
  wire [1:0] wrong_nxt = (pass_try && pass_good) ? 2'h0 :
                         (pass_try && wrong_cnt_r != ACCESS_TRIES) ? wrong_cnt_r + 2'h1 : wrong_cnt_r;  // [R20]

  // Setting rounding: nearest multiple of the step, half rounds up.
  wire [16:0] round_sum = {1'b0, pwdata[15:0]} + {2'b00, step_r[15:1]};
  wire [16:0] round_q = (step_r == 16'h0000) ? 17'h0_0000 : round_sum / {1'b0, step_r};
  wire [32:0] round_prod = round_q * {17'h0_0000, step_r};
  wire [15:0] rounded = (step_r == 16'h0000) ? pwdata[15:0] : round_prod[15:0];  // [R23]
  wire setting_wr = wr & hit_setting;
  wire round_changed = rounded != pwdata[15:0];

  // Fault detection, re-evaluated every cycle.
  logic [NUM_FAULTS-1:0] fault_now;
  assign fault_now[F_NVM] = pin_s2_r[0];  // [R08]
  assign fault_now[F_EQN] = ~cfg_eqn_ok;  // [R09]
  assign fault_now[F_DSP] = pin_s2_r[1];  // [R10]
  assign fault_now[F_XFMR] = ~cfg_xfmr_ok;  // [R11]
  assign fault_now[F_LOGIC_PWR] = ~pin_s2_r[2];  // [R12]
  assign fault_now[F_ANALOG_PWR] = ~pin_s2_r[3];  // [R13]
  assign fault_now[F_UNCAL] = ~cfg_calibrated;  // [R14]
  assign fault_now[F_RTC] = ~rtc_run_r;  // [R15]
  assign fault_now[F_BATT] = ~pin_s2_r[5];  // [R16]
  assign fault_now[F_DEVFW] = cfg_dev_fw;  // [R17]
  assign fault_now[F_INT_TEMP] = (int_temp < INT_TEMP_MIN) || (int_temp > INT_TEMP_MAX);  // [R18]
  assign fault_now[F_IRIG] = pin_s2_r[7:6] != cfg_irig_type;  // [R19]
  assign fault_now[F_ACCESS] = wrong_cnt_r == ACCESS_TRIES;  // [R20]
  assign fault_now[F_AMBIENT] = (amb_temp < AMB_TEMP_MIN) || (amb_temp > AMB_TEMP_MAX);  // [R21]

  // Severity classes; the major response overrides the minor one downstream.
  wire major_now = |(fault_r & MAJOR_MASK);  // [R24]
  wire minor_now = |(fault_r & ~MAJOR_MASK);  // [R24]

  // The clock stays stopped once it halts, until software writes the time again.
  wire rtc_run_nxt = (wr & hit_rtc_set) ? 1'b1 : (pin_s2_r[4] ? rtc_run_r : 1'b0);  // [R15]

  fault_evt_if evt_bus ();
  assign evt_bus.active = fault_r;

  fault_event_scanner u_scan (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .evt(evt_bus.scanner)
  );

  // Read data mux.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_status) rdata_nxt = {26'h000_0000, rtc_run_r, flash_active, protection_enable, minor_r, major_r,
                                 init_done_r};
    if (hit_faults) rdata_nxt = {18'h0_0000, fault_r};
    if (hit_config) rdata_nxt = config_r;
    if (hit_temps) rdata_nxt = temps_r;
    if (hit_pass_ref) rdata_nxt = pass_ref_r;
    if (hit_step) rdata_nxt = {16'h0000, step_r};
    if (hit_setting) rdata_nxt = {15'h0000, adjusted_r, setting_r};
    if (hit_flash) rdata_nxt = {23'h00_0000, flash_active, flash_code};
  end

  // APB slave: one wait-free access phase after each setup phase.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Software registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      config_r <= CONFIG_RST;
      temps_r <= TEMPS_RST;
      pass_ref_r <= PASS_REF_RST;
      step_r <= STEP_RST;
      setting_r <= 16'h0000;
      adjusted_r <= 1'b0;
      wrong_cnt_r <= 2'h0;
      rtc_run_r <= 1'b1;
    end else if (ce) begin
      if (wr && hit_config) config_r <= {16'h0000, pwdata[15:8], 2'h0, pwdata[5:0]};
      if (wr && hit_temps) temps_r <= {6'h00, pwdata[25:16], 8'h00, pwdata[7:0]};
      if (wr && hit_pass_ref) pass_ref_r <= pwdata;
      if (wr && hit_step) step_r <= pwdata[15:0];
      if (setting_wr) begin
        setting_r <= rounded;  // [R23]
        adjusted_r <= round_changed;
      end
      wrong_cnt_r <= wrong_nxt;
      rtc_run_r <= rtc_run_nxt;
    end
  end

  // Fault state and the power-up pass: in service only after one full scan.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_r <= '0;
      major_r <= 1'b0;
      minor_r <= 1'b0;
      init_done_r <= 1'b0;
    end else if (ce) begin
      fault_r <= fault_now;  // [R01]
      major_r <= major_now;
      minor_r <= minor_now;
      if (evt_bus.scan_wrap) init_done_r <= 1'b1;  // [R01]
    end
  end

  // Front-panel indicators and relays, driven from registered severity.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      protection_enable <= 1'b0;
      eqn_feature_enable <= 1'b0;
      fault_led <= 1'b0;
      in_service_led <= 1'b0;
      relay_drive <= '0;
      watchdog_relay <= 1'b0;
      rtc_run <= 1'b0;
    end else if (ce) begin
      protection_enable <= init_done_r & ~major_r;  // [R02] [R24]
      eqn_feature_enable <= init_done_r & ~fault_r[F_EQN];  // [R09]
      fault_led <= major_r | minor_r;  // [R03] [R05]
      in_service_led <= init_done_r & ~major_r;  // [R03]
      relay_drive <= (init_done_r & ~major_r) ? relay_cmd : '0;  // [R04] [R05]
      watchdog_relay <= init_done_r & ~major_r & ~minor_r;  // [R04] [R05]
      rtc_run <= rtc_run_r;
    end
  end

  // Each newly raised fault goes to the target queue and the event log together.
  wire evt_major = MAJOR_MASK[evt_bus.evt_code];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tq_valid <= 1'b0;
      tq_code <= '0;
      log_valid <= 1'b0;
      log_code <= '0;
      log_major <= 1'b0;
    end else if (ce) begin
      tq_valid <= evt_bus.evt_valid;  // [R06]
      tq_code <= evt_bus.evt_code;
      log_valid <= evt_bus.evt_valid;  // [R07]
      log_code <= evt_bus.evt_code;
      log_major <= evt_major;
    end
  end

  // Flash message timer. A duration of zero still shows the message for one second.
  wire flash_start = (wr & hit_flash) | (setting_wr & round_changed);
  wire sec_tick = sec_cnt_r == 32'(SEC_CYCLES - 1);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flash_active <= 1'b0;
      flash_code <= 8'h00;
      flash_left_r <= 8'h00;
      sec_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      if (flash_start) begin
        flash_active <= 1'b1;  // [R22]
        flash_code <= setting_wr ? FLASH_CODE_ADJUSTED : pwdata[7:0];  // [R23]
        flash_left_r <= (cfg_flash_sec == 8'h00) ? 8'h01 : cfg_flash_sec;  // [R22]
        sec_cnt_r <= 32'h0000_0000;
      end else if (flash_active) begin
        sec_cnt_r <= sec_tick ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
        if (sec_tick) begin
          flash_left_r <= flash_left_r - 8'h01;
          if (flash_left_r == 8'h01) flash_active <= 1'b0;  // [R22]
        end
      end
    end
  end

  // Assertions.
  sequence s_major_seen;
    ce && major_r && init_done_r;
  endsequence
  sequence s_outputs_safe;
    !protection_enable && relay_drive == '0 && !watchdog_relay && fault_led && !in_service_led;
  endsequence
  sequence s_minor_only;
    ce && minor_r && !major_r && init_done_r;
  endsequence
  sequence s_minor_resp;
    fault_led && !watchdog_relay && protection_enable && relay_drive == $past(relay_cmd);
  endsequence

  a_major_response: assert property (@(posedge sys_clk) disable iff (srst)  // [R02] [R03] [R04]
    s_major_seen |=> s_outputs_safe)
    else $error("major fault did not force the safe outputs");
  a_minor_response: assert property (@(posedge sys_clk) disable iff (srst)  // [R05]
    s_minor_only |=> s_minor_resp)
    else $error("minor fault response wrong");
  a_response_withdraw: assert property (@(posedge sys_clk) disable iff (srst)  // [R24]
    (ce && init_done_r && !major_r && !minor_r) |=> (watchdog_relay && !fault_led && in_service_led))
    else $error("responses not withdrawn after faults cleared");
  a_queue_log_pair: assert property (@(posedge sys_clk) disable iff (srst)  // [R06] [R07]
    tq_valid |-> (log_valid && log_code == tq_code && log_major == MAJOR_MASK[tq_code]))
    else $error("target queue and event log disagree");
  a_fault_reported: assert property (@(posedge sys_clk) disable iff (srst || !ce)  // [R06] [R07]
    $rose(fault_r[F_DSP]) |-> ##[1:16] (tq_valid && tq_code == F_DSP))
    else $error("raised fault not reported in time");
  a_access_lockout: assert property (@(posedge sys_clk) disable iff (srst || !ce)  // [R20]
    (wrong_cnt_r == 2'h2 && pass_try && !pass_good) |=> ##1 fault_r[F_ACCESS])
    else $error("third wrong passcode did not raise the fault");
  a_access_clear: assert property (@(posedge sys_clk) disable iff (srst)  // [R20]
    (ce && pass_try && pass_good) |=> wrong_cnt_r == 2'h0)
    else $error("correct passcode did not clear the count");
  a_rtc_hold: assert property (@(posedge sys_clk) disable iff (srst)  // [R15]
    (!rtc_run_r && !(wr && hit_rtc_set)) |=> !rtc_run_r)
    else $error("clock restarted without a time write");
  a_setting_round: assert property (@(posedge sys_clk) disable iff (srst)  // [R23]
    (ce && setting_wr && step_r != 16'h0000) |=> (adjusted_r == (setting_r != $past(pwdata[15:0]))))
    else $error("adjusted flag does not match rounding");
  a_flash_start: assert property (@(posedge sys_clk) disable iff (srst)  // [R22]
    (ce && flash_start) |=> (flash_active && flash_left_r != 8'h00))
    else $error("flash message not started");
  a_temp_limits: assert property (@(posedge sys_clk) disable iff (srst)  // [R18]
    (ce && int_temp == INT_TEMP_MAX) |=> !fault_r[F_INT_TEMP])
    else $error("limit value itself flagged as fault");
endmodule : self_test_error_handler

/* File: self_test_pkg.sv */
// Shared constants for the self-test error handler: fault indices, register map and limits.
package self_test_pkg;
  localparam int NUM_FAULTS = 14;
  localparam int FW = 4;

  // Fault indices; the first four are major, the rest minor.
  localparam logic [3:0] F_NVM = 4'h0;
  localparam logic [3:0] F_EQN = 4'h1;
  localparam logic [3:0] F_DSP = 4'h2;
  localparam logic [3:0] F_XFMR = 4'h3;
  localparam logic [3:0] F_LOGIC_PWR = 4'h4;
  localparam logic [3:0] F_ANALOG_PWR = 4'h5;
  localparam logic [3:0] F_UNCAL = 4'h6;
  localparam logic [3:0] F_RTC = 4'h7;
  localparam logic [3:0] F_BATT = 4'h8;
  localparam logic [3:0] F_DEVFW = 4'h9;
  localparam logic [3:0] F_INT_TEMP = 4'hA;
  localparam logic [3:0] F_IRIG = 4'hB;
  localparam logic [3:0] F_ACCESS = 4'hC;
  localparam logic [3:0] F_AMBIENT = 4'hD;
  localparam logic [13:0] MAJOR_MASK = 14'h000F;

  // Register byte offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_FAULTS = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_TEMPS = 8'h0C;
  localparam logic [7:0] OFF_PASS_REF = 8'h10;
  localparam logic [7:0] OFF_PASS_TRY = 8'h14;
  localparam logic [7:0] OFF_RTC_SET = 8'h18;
  localparam logic [7:0] OFF_STEP = 8'h1C;
  localparam logic [7:0] OFF_SETTING = 8'h20;
  localparam logic [7:0] OFF_FLASH = 8'h24;

  // Reset values.
  localparam logic [31:0] CONFIG_RST = 32'h0000_0406;
  localparam logic [31:0] TEMPS_RST = 32'h0019_0019;
  localparam logic [31:0] PASS_REF_RST = 32'h0000_0000;
  localparam logic [15:0] STEP_RST = 16'h0001;
  // Synchroniser reset levels equal the healthy pin levels, so leaving reset raises no false fault.
  // Bit order: memory, link, logic supply, analog supply, clock oscillator, battery, time-code[1:0].
  localparam logic [7:0] PIN_SYNC_RST = 8'h3C;

  // Temperature limits in degrees C, two's complement.
  localparam logic signed [7:0] INT_TEMP_MIN = 8'shD8;
  localparam logic signed [7:0] INT_TEMP_MAX = 8'sh55;
  localparam logic signed [9:0] AMB_TEMP_MIN = 10'sh3CE;
  localparam logic signed [9:0] AMB_TEMP_MAX = 10'sh0FA;

  localparam logic [1:0] ACCESS_TRIES = 2'h3;
  localparam logic [7:0] FLASH_CODE_ADJUSTED = 8'h01;
  localparam int SYS_CLK_MHZ = 250;
  localparam int ONE_SECOND_US = 1000000;
  localparam int CYCLES_PER_SEC = SYS_CLK_MHZ * ONE_SECOND_US;
endpackage : self_test_pkg

/* File: fault_evt_if.sv */
// Carries the active fault vector to the scanner and its one-per-cycle fault events back.
interface fault_evt_if;
  import self_test_pkg::*;
  logic [NUM_FAULTS-1:0] active;
  logic evt_valid;
  logic [FW-1:0] evt_code;
  logic scan_wrap;
  modport scanner (input active, output evt_valid, evt_code, scan_wrap);
  modport handler (output active, input evt_valid, evt_code, scan_wrap);
endinterface : fault_evt_if

/* File: fault_event_scanner.sv */
// Turns newly raised faults into a serial stream of fault events, one index per cycle.
module fault_event_scanner
  import self_test_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  fault_evt_if.scanner evt
);
  logic [NUM_FAULTS-1:0] prev_r;
  logic [NUM_FAULTS-1:0] pending_r;
  logic [NUM_FAULTS-1:0] pending_nxt;
  logic [NUM_FAULTS-1:0] rise;
  logic [NUM_FAULTS-1:0] taken;
  logic [FW-1:0] idx_r;
  logic [FW-1:0] idx_nxt;
  logic valid_r;
  logic [FW-1:0] code_r;
  logic wrap_r;
  wire last_idx = (idx_r == FW'(NUM_FAULTS - 1));

  // A fault present when reset releases counts as newly raised; the first pass reports it, except memory, equation and link faults, which wait for the second.
  assign rise = evt.active & ~prev_r;
  assign taken = (NUM_FAULTS'(1) << idx_r) & pending_r;
  // A rise in the same cycle as its emission stays pending: set wins over clear.
  assign pending_nxt = (pending_r & ~taken) | rise;
  assign idx_nxt = last_idx ? '0 : idx_r + FW'(1);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prev_r <= '0;
      pending_r <= '0;
      idx_r <= '0;
      valid_r <= 1'b0;
      code_r <= '0;
      wrap_r <= 1'b0;
    end else if (ce) begin
      prev_r <= evt.active;
      pending_r <= pending_nxt;
      idx_r <= idx_nxt;
      valid_r <= |taken;
      code_r <= idx_r;
      wrap_r <= last_idx;
    end
  end

  assign evt.evt_valid = valid_r;
  assign evt.evt_code = code_r;
  assign evt.scan_wrap = wrap_r;
endmodule : fault_event_scanner

/* File: panel_log_model.sv */
// Model of the target queue and event log that collect fault entries from the handler.
module panel_log_model
  import self_test_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic tq_valid,
  input wire logic [FW-1:0] tq_code,
  input wire logic log_valid,
  input wire logic [FW-1:0] log_code,
  input wire logic log_major,
  output int entries,
  output int pair_errs,
  output logic [FW-1:0] last_code,
  output logic last_major
);
  timeunit 1ns;
  timeprecision 1ps;
  // A queue message without its log entry would leave a fault unrecorded, so both are counted together.
  always @(posedge sys_clk) begin
    if (srst) begin
      entries <= 0;
      pair_errs <= 0;
      last_code <= 4'h0;
      last_major <= 1'b0;
    end else begin
      if (tq_valid !== log_valid || (log_valid === 1'b1 && tq_code !== log_code)) begin
        pair_errs <= pair_errs + 1;
      end
      if (log_valid === 1'b1) begin
        entries <= entries + 1;
        last_code <= log_code;
        last_major <= log_major;
      end
    end
  end
endmodule : panel_log_model

/* File: self_test_error_handler_test.sv */
// Self-checking testbench for the self-test error handler.
module self_test_error_handler_test
  import self_test_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CFG_OK = 32'h0000_0407;
  logic sys_clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready, perr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, d;
  logic nvm_uncorrectable = 0, dsp_link_lost = 0, logic_supply_ok = 1, analog_supply_ok = 1;
  logic rtc_osc_ok = 1, battery_ok = 1;
  logic [1:0] irig_format = 2'h0;
  logic [6:0] relay_cmd = 7'h55, relay_drive;
  logic protection_enable, eqn_feature_enable, fault_led, in_service_led, watchdog_relay, rtc_run;
  logic tq_valid, log_valid, log_major, flash_active, last_major, mj;
  logic [3:0] tq_code, log_code, last_code;
  logic [7:0] flash_code;
  int fails = 0, compares = 0, entries, pair_errs, n;
  always #2 sys_clk = ~sys_clk;
  self_test_error_handler #(.NUM_RELAYS(7), .SEC_CYCLES(20)) uut (.sys_clk, .srst, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nvm_uncorrectable, .dsp_link_lost,
    .logic_supply_ok, .analog_supply_ok, .rtc_osc_ok, .battery_ok, .irig_format, .relay_cmd,
    .protection_enable, .eqn_feature_enable, .fault_led, .in_service_led, .relay_drive, .watchdog_relay,
    .rtc_run, .tq_valid, .tq_code, .log_valid, .log_code, .log_major, .flash_active, .flash_code);
  panel_log_model partner (.sys_clk, .srst, .tq_valid, .tq_code, .log_valid, .log_code, .log_major,
    .entries, .pair_errs, .last_code, .last_major);
  task automatic print_verdict();
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : wait_cyc
  // Starting on a fresh edge keeps the release of one transfer and the next setup in separate steps.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 32'(a);
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic apb_write(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask : apb_write
  task automatic apb_read(input logic [7:0] a, output logic [31:0] rd);
    apb(1'b0, a, 32'h0000_0000, rd);
  endtask : apb_read
  task automatic set_fault(input int idx, input logic on);
    case (idx)
      0: nvm_uncorrectable <= on;
      1: apb_write(OFF_CONFIG, on ? 32'h0000_0405 : CFG_OK);
      2: dsp_link_lost <= on;
      3: apb_write(OFF_CONFIG, on ? 32'h0000_0403 : CFG_OK);
      4: logic_supply_ok <= !on;
      5: analog_supply_ok <= !on;
      6: apb_write(OFF_CONFIG, on ? 32'h0000_0406 : CFG_OK);
      7: begin
        rtc_osc_ok <= !on;
        if (!on) begin
          wait_cyc(20);
          check(rtc_run, 0);
          apb_read(OFF_FAULTS, d);
          check(d, 32'h0000_0080);
          apb_write(OFF_RTC_SET, 32'h0000_0000);
        end
      end
      8: battery_ok <= !on;
      9: apb_write(OFF_CONFIG, on ? 32'h0000_040F : CFG_OK);
      10: apb_write(OFF_TEMPS, on ? 32'h0019_00D7 : 32'h0019_0055);
      11: irig_format <= on ? 2'h1 : 2'h0;
      12: begin
        if (on) begin
          apb_write(OFF_PASS_TRY, 32'h0000_0001);
          apb_write(OFF_PASS_TRY, 32'h0000_0001);
          wait_cyc(5);
          apb_read(OFF_FAULTS, d);
          check(d, 32'h0000_0000);
        end
        apb_write(OFF_PASS_TRY, on ? 32'h0000_0001 : 32'h0000_0000);
      end
      default: apb_write(OFF_TEMPS, on ? 32'h00FB_0019 : 32'h03CE_00D8);
    endcase
  endtask : set_fault
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    wait_cyc(2);
    check(protection_enable, 0);
    wait_cyc(40);
    apb_read(OFF_STATUS, d);
    check(d, 32'h0000_002D);
    check(last_code, F_UNCAL);
    check(watchdog_relay, 0);
    apb_read(OFF_CONFIG, d);
    check(d, CONFIG_RST);
    apb_read(OFF_TEMPS, d);
    check(d, TEMPS_RST);
    apb_read(OFF_STEP, d);
    check(d, 32'(STEP_RST));
    apb_read(OFF_PASS_REF, d);
    check(d, PASS_REF_RST);
    apb_read(8'h40, d);
    check(d, 32'h0000_0000);
    check(perr, 1);
    apb_write(OFF_CONFIG, CFG_OK);
    wait_cyc(30);
    check({protection_enable, in_service_led, watchdog_relay, fault_led, relay_drive}, 11'h755);
    check(eqn_feature_enable, 1);
    for (int i = 0; i < NUM_FAULTS; i++) begin
      n = entries;
      mj = MAJOR_MASK[i];
      set_fault(i, 1'b1);
      wait_cyc(30);
      apb_read(OFF_FAULTS, d);
      check(d, 32'h0000_0001 << i);
      check({protection_enable, in_service_led}, {2{!mj}});
      check({fault_led, watchdog_relay}, 2'h2);
      check(relay_drive, mj ? 7'h00 : 7'h55);
      check(entries, n + 1);
      check({last_code, last_major}, {4'(i), mj});
      if (i == 1) check(eqn_feature_enable, 0);
      set_fault(i, 1'b0);
      wait_cyc(30);
      apb_read(OFF_FAULTS, d);
      check(d, 32'h0000_0000);
      check({protection_enable, watchdog_relay, fault_led, relay_drive}, 10'h355);
    end
    set_fault(2, 1'b1);
    set_fault(4, 1'b1);
    wait_cyc(30);
    check({protection_enable, watchdog_relay, relay_drive}, 9'h000);
    set_fault(2, 1'b0);
    wait_cyc(30);
    check({protection_enable, watchdog_relay, fault_led, relay_drive}, 10'h2D5);
    set_fault(4, 1'b0);
    apb_write(OFF_STEP, 32'h0000_000A);
    apb_write(OFF_SETTING, 32'h0000_000F);
    apb_read(OFF_SETTING, d);
    check(d, 32'h0001_0014);
    check({flash_active, flash_code}, {1'b1, FLASH_CODE_ADJUSTED});
    wait_cyc(65);
    check(flash_active, 1);
    wait_cyc(25);
    check(flash_active, 0);
    apb_write(OFF_SETTING, 32'h0000_0014);
    apb_read(OFF_SETTING, d);
    check(d, 32'h0000_0014);
    check(flash_active, 0);
    // With the enable low the link loss must not reach the outputs until it returns.
    ce <= 1'b0;
    dsp_link_lost <= 1'b1;
    wait_cyc(10);
    check(protection_enable, 1);
    ce <= 1'b1;
    wait_cyc(10);
    check(protection_enable, 0);
    dsp_link_lost <= 1'b0;
    wait_cyc(30);
    check(protection_enable, 1);
    check(pair_errs, 0);
    print_verdict();
  end
endmodule : self_test_error_handler_test
